// ---- scp_pkg.sv ----
// Purpose: Shared types and constants for the text command interpreter.
// Assumes: ASCII program messages arrive one byte at a time.
// Notes: Keyword text is right aligned so it lines up with the shifted-in word.
package scp_pkg;

  typedef enum logic [4:0] {
    TK_NONE, TK_MEAS, TK_CONF, TK_FETC, TK_READ, TK_DISP, TK_CALC, TK_SENS,
    TK_SYST, TK_UNIT, TK_TRIG, TK_VOLT, TK_CURR, TK_RES, TK_FRES, TK_FREQ,
    TK_PER, TK_DIOD, TK_CONT, TK_DC, TK_AC, TK_RST, TK_TRG, TK_IDN
  } scp_tok_t;

  localparam int KW_NUM = 24;
  localparam logic [95:0] KW_TEXT [KW_NUM] = '{
    96'h0, "MEASURE", "CONFIGURE", "FETCH", "READ", "DISPLAY", "CALCULATE",
    "SENSE", "SYSTEM", "UNIT", "TRIGGER", "VOLTAGE", "CURRENT", "RESISTANCE",
    "FRESISTANCE", "FREQUENCY", "PERIOD", "DIODE", "CONTINUITY", "DC", "AC",
    "RST", "TRG", "IDN"};
  localparam logic [3:0] KW_SHORT [KW_NUM] = '{
    4'hf, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4,
    4'h4, 4'h3, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3};
  localparam logic [3:0] KW_FULL_LEN [KW_NUM] = '{
    4'hf, 4'h7, 4'h9, 4'h5, 4'h4, 4'h7, 4'h9, 4'h5, 4'h6, 4'h4, 4'h7, 4'h7,
    4'h7, 4'ha, 4'hb, 4'h9, 4'h6, 4'h5, 4'ha, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3};
  localparam logic [3:0] WORD_MAX = 4'hc;

  typedef enum logic [3:0] {
    FN_VDC, FN_VAC, FN_IDC, FN_IAC, FN_RES2, FN_RES4, FN_FREQ, FN_PER,
    FN_DIODE, FN_CONT
  } scp_func_t;
  localparam logic [55:0] FN_NAME [10] = '{
    "volt:dc", "volt:ac", "curr:dc", "curr:ac", "res", "fres", "freq", "per",
    "diod", "cont"};
  localparam logic [4:0] FN_LEN [10] = '{
    5'h07, 5'h07, 5'h07, 5'h07, 5'h03, 5'h04, 5'h04, 5'h03, 5'h04, 5'h04};

  typedef enum logic [2:0] {
    ST_RX = 3'b000, ST_EXEC = 3'b001, ST_ABORT = 3'b011, ST_CONF = 3'b010,
    ST_INIT = 3'b110, ST_WAIT = 3'b111, ST_SEND = 3'b101
  } scp_state_t;

  typedef enum logic [2:0] {LD_NONE, LD_LAST, LD_NEW, LD_FN, LD_IDN} scp_load_t;

  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_E = 8'h45;

  localparam logic [15:0] ERR_UNDEF = 16'hff8f;
  localparam logic [15:0] ERR_INIT = 16'hff2b;
  localparam logic [15:0] ERR_OOM = 16'hff1f;
  localparam logic [15:0] ERR_FETCH = 16'hff1a;

  // Arbitrary identification text returned by the identity query.
  localparam logic [63:0] IDN_TEXT = "XDMM,000";

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam logic [7:0] REG_DELAY = 8'h0c;
  localparam int CTRL_CONT = 0;
  localparam int CTRL_MATH = 1;
  localparam int CTRL_BUF = 2;
  localparam int CTRL_TIMM = 3;
  localparam int CTRL_AZ = 4;
  localparam logic CONT_RST = 1'b0;
  localparam logic AZ_RST = 1'b1;
  localparam logic TIMM_RST = 1'b1;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scp_wb_req_t;

  typedef struct packed {
    logic neg;
    logic [27:0] mant;
    logic exp_neg;
    logic [11:0] exp;
  } scp_reading_t;

  typedef struct packed {
    logic abort;
    logic restart;
    logic init;
    logic configure;
    logic store_abort;
    logic rst;
    logic trg;
  } scp_meas_ctl_t;

endpackage : scp_pkg

// ---- scp_parser.sv ----
// Purpose: Text command interpreter with the measurement command group.
// Assumes: Bytes arrive on a valid/ready stream; readings come in as BCD.
// Notes: Subsystems other than measurement are accepted and their rest skipped.
// Operation
// RQ1: Semicolons split one line into commands executed one after another.
// RQ2: After a bare semicolon the next word resolves at the previous level.
// RQ3: Semicolon then colon restarts at the top of the tree.
// RQ4: Star commands only at line start or right after a semicolon.
// RQ5: Every new message resolves from root; an optional root may be omitted.
// RQ6: A leading colon at message start changes nothing.
// RQ7: Each colon between words moves the path one level down.
// RQ8: A colon right after a semicolon resets the path to root.
// RQ9: The path never moves up except by restarting at root.
// RQ10: Accept six subsystem roots and only the reset, trigger, identity commands.
// RQ11: Measure query does abort, configure, read and returns one reading.
// RQ12: Configure selects one of ten measurement functions.
// RQ13: Abort idles when continuous is off, else restarts the trigger model.
// RQ14: Configure selects function, defaults its controls, clears continuous.
// RQ15: Configure sets trigger source immediate and trigger delay zero.
// RQ16: Configure disables math and buffer, aborts storage, defaults autozero.
// RQ17: Configure query returns the function as short lower-case path.
// RQ18: Fetch returns the latest reading, repeated until a newer one exists.
// RQ19: Standalone fetch errors when continuous initiation is off.
// RQ20: Read query does abort, initiate, fetch and returns the reading.
// RQ21: Initiate leaves idle; with continuous on it errors, fetch still runs.
// RQ22: Read is refused with out-of-memory while the buffer holds readings.
// RQ23: Words match in any letter case; a question mark makes a query.
// RQ24: Words match in full or in four-letter short form; the code takes three-letter short forms for RES and PER.
// RQ25: Readings go out as sign, digit, point, six digits, exponent, newline.
// RQ26: An unresolvable word raises an error and skips to the next separator.
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/1ps

module scp_parser
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire scp_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire scp_reading_t reading,
  input wire logic reading_new,
  input wire logic [9:0] buf_count,
  output scp_meas_ctl_t meas_ctl,
  output scp_func_t func,
  output logic trig_idle
);

  scp_state_t st_q, st_d;
  logic [95:0] word_q;
  logic [3:0] wlen_q;
  logic wovf_q;
  scp_tok_t path_q [3];
  scp_tok_t common_tok_q;
  logic [1:0] lvl_q, wlvl_q;
  logic query_q, common_q, bad_q, skip_q, at_start_q, after_semi_q, msg_start_q;
  logic cmd_q;
  logic do_conf_q, do_read_q;
  scp_func_t func_q, pend_fn_q;
  logic cont_q, math_q, buf_q, timm_q, az_q, trig_idle_q;
  logic [15:0] delay_q, err_code_q;
  logic err_flag_q;
  scp_reading_t reading_q;
  logic [127:0] tx_buf_q;
  logic [4:0] tx_cnt_q;
  logic ack_q;
  logic [31:0] dat_q;

  function automatic scp_tok_t kw_match(input logic [95:0] w, input logic [3:0] n);
    scp_tok_t t;
    t = TK_NONE;
    for (int k = 1; k < KW_NUM; k++)
    begin
      if ((n == KW_SHORT[k] || n == KW_FULL_LEN[k]) &&
          w == (KW_TEXT[k] >> (8 * (KW_FULL_LEN[k] - n))))
        t = scp_tok_t'(k);
    end
    return t;
  endfunction : kw_match

  function automatic logic [127:0] fmt_reading(input scp_reading_t r);
    logic [55:0] md;
    logic [23:0] ed;
    logic [7:0] sg;
    md = '0;
    ed = '0;
    for (int i = 0; i < 7; i++)
      md[55 - 8 * i -: 8] = {4'h3, r.mant[27 - 4 * i -: 4]};
    for (int i = 0; i < 3; i++)
      ed[23 - 8 * i -: 8] = {4'h3, r.exp[11 - 4 * i -: 4]};
    sg = r.neg ? CH_MINUS : CH_PLUS;
    if (r.exp_neg)
      return {sg, md[55:48], CH_DOT, md[47:0], CH_E, CH_MINUS, ed, CH_NL, 8'h00};
    return {sg, md[55:48], CH_DOT, md[47:0], CH_E, ed, CH_NL, 16'h0000};
  endfunction : fmt_reading

  // RQ23 case folding
  logic [7:0] ch;
  logic take, is_alpha, is_digit, has_word, is_sep, word_end;
  assign ch = (rx_data >= 8'h61 && rx_data <= 8'h7a) ? rx_data - 8'h20 : rx_data;
  assign rx_ready = (st_q == ST_RX);
  assign take = rx_ready && rx_valid;
  assign is_alpha = (ch >= 8'h41 && ch <= 8'h5a);
  assign is_digit = (ch >= 8'h30 && ch <= 8'h39);
  assign has_word = (wlen_q != 4'h0) && !skip_q;
  assign is_sep = (ch == CH_SEMI) || (ch == CH_NL);
  assign word_end = is_sep || ch == CH_COLON || ch == CH_QMARK || ch == CH_SPACE;

  // Resolve the finished word against the tree at the current level.
  scp_tok_t tok;
  logic rs_ok, rs_skip, parse_err;
  always_comb
  begin
    // RQ24 full or short form
    tok = wovf_q ? TK_NONE : kw_match(word_q, wlen_q);
    rs_ok = 1'b0;
    rs_skip = 1'b0;
    // RQ10 accepted roots and commons
    if (common_q)
      rs_ok = tok inside {TK_RST, TK_TRG, TK_IDN};
    else
      unique case (lvl_q)
        2'd0:
        begin
          // RQ5 optional root: function words fall under the sense subsystem
          rs_ok = tok inside {[TK_MEAS:TK_CONT]};
          rs_skip = tok inside {[TK_DISP:TK_CONT]};
        end
        2'd1: rs_ok = path_q[0] inside {TK_MEAS, TK_CONF} && tok inside {[TK_VOLT:TK_CONT]};
        2'd2: rs_ok = path_q[1] inside {TK_VOLT, TK_CURR} && tok inside {TK_DC, TK_AC};
        default: rs_ok = 1'b0;
      endcase
    parse_err = 1'b0;
    if (take && !skip_q)
    begin
      // RQ26 unknown word
      if (word_end && has_word && !rs_ok)
        parse_err = 1'b1;
      // RQ6 leading colon allowed
      else if (ch == CH_COLON && !has_word && !after_semi_q && !msg_start_q)
        parse_err = 1'b1;
      // RQ4 star only at a command start
      else if (ch == CH_STAR && !(at_start_q && wlen_q == 4'h0))
        parse_err = 1'b1;
      else if (!word_end && !is_alpha && !is_digit && ch != CH_STAR)
        parse_err = 1'b1;
    end
  end

  // Parser state: word buffer, path pointer and command flags.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      word_q <= '0;
      wlen_q <= 4'h0;
      wovf_q <= 1'b0;
      path_q <= '{TK_NONE, TK_NONE, TK_NONE};
      common_tok_q <= TK_NONE;
      lvl_q <= 2'd0;
      wlvl_q <= 2'd0;
      {query_q, common_q, bad_q, skip_q, cmd_q} <= 5'b00000;
      {at_start_q, after_semi_q, msg_start_q} <= 3'b101;
    end
    else if (st_q == ST_EXEC)
      {query_q, common_q, bad_q, cmd_q} <= 4'b0000;
    else if (take)
    begin
      if (word_end)
      begin
        word_q <= '0;
        wlen_q <= 4'h0;
        wovf_q <= 1'b0;
      end
      if (word_end && has_word && rs_ok)
      begin
        cmd_q <= 1'b1;
        if (common_q)
          common_tok_q <= tok;
        else
        begin
          // Deeper entries are cleared so a stale function never leaks in.
          for (int k = 0; k < 3; k++)
            if (k > lvl_q)
              path_q[k] <= TK_NONE;
          path_q[lvl_q] <= tok;
          wlvl_q <= lvl_q;
        end
        if (rs_skip)
          skip_q <= 1'b1;
      end
      if (parse_err)
      begin
        bad_q <= 1'b1;
        skip_q <= 1'b1;
      end
      // RQ1 separator ends one command
      if (is_sep)
      begin
        skip_q <= 1'b0;
        at_start_q <= 1'b1;
        after_semi_q <= (ch == CH_SEMI);
        msg_start_q <= (ch == CH_NL);
        // RQ2 RQ5 level for the next word
        lvl_q <= (ch == CH_NL) ? 2'd0 : (has_word && rs_ok && !common_q) ? lvl_q : wlvl_q;
      end
      else
      begin
        at_start_q <= 1'b0;
        after_semi_q <= 1'b0;
        msg_start_q <= 1'b0;
      end
      if (!skip_q && !parse_err)
      begin
        // RQ3 RQ8 restart at root
        if (ch == CH_COLON && !has_word && after_semi_q)
          lvl_q <= 2'd0;
        // RQ7 RQ9 colon only ever moves down
        else if (ch == CH_COLON && has_word && lvl_q != 2'd3)
          lvl_q <= lvl_q + 2'd1;
        if (ch == CH_QMARK)
        begin
          query_q <= 1'b1;
          skip_q <= 1'b1;
        end
        if (ch == CH_SPACE)
          skip_q <= 1'b1;
        if (ch == CH_STAR)
          common_q <= 1'b1;
        if (is_alpha && wlen_q == WORD_MAX)
          wovf_q <= 1'b1;
        else if (is_alpha)
        begin
          word_q <= {word_q[87:0], ch};
          wlen_q <= wlen_q + 4'h1;
        end
      end
    end
  end

  // Command decode at the end of each command.
  scp_func_t ex_fn;
  logic ex_fn_ok, ex_err;
  logic [15:0] ex_code;
  scp_load_t ld;
  always_comb
  begin
    ex_fn_ok = 1'b1;
    unique case (path_q[1])
      TK_VOLT: ex_fn = (path_q[2] == TK_AC) ? FN_VAC : FN_VDC;
      TK_CURR: ex_fn = (path_q[2] == TK_AC) ? FN_IAC : FN_IDC;
      TK_RES: ex_fn = FN_RES2;
      TK_FRES: ex_fn = FN_RES4;
      TK_FREQ: ex_fn = FN_FREQ;
      TK_PER: ex_fn = FN_PER;
      TK_DIOD: ex_fn = FN_DIODE;
      TK_CONT: ex_fn = FN_CONT;
      default:
      begin
        ex_fn = FN_VDC;
        ex_fn_ok = 1'b0;
      end
    endcase
    st_d = st_q;
    ex_err = 1'b0;
    ex_code = ERR_UNDEF;
    ld = LD_NONE;
    unique case (st_q)
      ST_RX: st_d = (take && is_sep) ? ST_EXEC : ST_RX;
      ST_EXEC:
      begin
        st_d = ST_RX;
        // An empty command must not replay the path left by the one before.
        if (bad_q || !cmd_q)
          st_d = ST_RX;
        else if (common_q)
        begin
          if (common_tok_q == TK_IDN && query_q)
          begin
            ld = LD_IDN;
            st_d = ST_SEND;
          end
        end
        else
          unique case (path_q[0])
            TK_MEAS, TK_READ:
              if (!query_q || (path_q[0] == TK_MEAS && !ex_fn_ok))
                ex_err = 1'b1;
              // RQ22 buffer must be empty
              else if (buf_count != 10'h000)
              begin
                ex_err = 1'b1;
                ex_code = ERR_OOM;
              end
              else
                st_d = ST_ABORT;
            TK_CONF:
              // RQ17 function query
              if (query_q && !ex_fn_ok)
              begin
                ld = LD_FN;
                st_d = ST_SEND;
              end
              else if (!query_q && ex_fn_ok)
                st_d = ST_CONF;
              else
                ex_err = 1'b1;
            TK_FETC:
              // RQ19 fetch needs continuous initiation
              if (!query_q)
                ex_err = 1'b1;
              else if (!cont_q)
              begin
                ex_err = 1'b1;
                ex_code = ERR_FETCH;
              end
              else
              begin
                ld = LD_LAST;
                st_d = ST_SEND;
              end
            default: st_d = ST_RX;
          endcase
      end
      // RQ11 RQ20 abort, configure, abort, initiate, fetch
      ST_ABORT: st_d = do_conf_q ? ST_CONF : ST_INIT;
      ST_CONF: st_d = do_read_q ? ST_ABORT : ST_RX;
      ST_INIT:
        // RQ21 ignored initiate still fetches
        if (cont_q)
        begin
          ex_err = 1'b1;
          ex_code = ERR_INIT;
          ld = LD_LAST;
          st_d = ST_SEND;
        end
        else
          st_d = ST_WAIT;
      ST_WAIT:
        if (reading_new)
        begin
          ld = LD_NEW;
          st_d = ST_SEND;
        end
      ST_SEND: st_d = (tx_cnt_q == 5'd1 && tx_ready) ? ST_RX : ST_SEND;
      default: st_d = ST_RX;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= ST_RX;
      do_conf_q <= 1'b0;
      do_read_q <= 1'b0;
      pend_fn_q <= FN_VDC;
    end
    else
    begin
      st_q <= st_d;
      if (st_q == ST_EXEC)
      begin
        do_conf_q <= (path_q[0] == TK_MEAS || path_q[0] == TK_CONF);
        do_read_q <= (path_q[0] == TK_MEAS || path_q[0] == TK_READ);
        pend_fn_q <= ex_fn;
      end
      if (st_q == ST_CONF)
        do_conf_q <= 1'b0;
    end
  end

  // Measurement controls; software writes lose to a configure in the same cycle.
  logic wr_ok;
  assign wr_ok = wb_req.cyc && wb_req.stb && wb_req.we && ack_q;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      func_q <= FN_VDC;
      {cont_q, math_q, buf_q, timm_q, az_q} <= {CONT_RST, 1'b0, 1'b0, TIMM_RST, AZ_RST};
      delay_q <= DELAY_RST;
    end
    // RQ12 RQ14 RQ15 RQ16 configure side effects
    else if (st_q == ST_CONF)
    begin
      func_q <= pend_fn_q;
      {cont_q, math_q, buf_q, timm_q, az_q} <= {1'b0, 1'b0, 1'b0, 1'b1, AZ_RST};
      delay_q <= 16'h0000;
    end
    else if (wr_ok && wb_req.adr == REG_CTRL && wb_req.sel[0])
      {az_q, timm_q, buf_q, math_q, cont_q} <= wb_req.dat[CTRL_AZ:CTRL_CONT];
    else if (wr_ok && wb_req.adr == REG_DELAY)
    begin
      if (wb_req.sel[0])
        delay_q[7:0] <= wb_req.dat[7:0];
      if (wb_req.sel[1])
        delay_q[15:8] <= wb_req.dat[15:8];
    end
  end

  // RQ13 trigger model idle tracking
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      trig_idle_q <= 1'b1;
    else if (st_q == ST_ABORT && !cont_q)
      trig_idle_q <= 1'b1;
    else if (st_q == ST_INIT && !cont_q)
      trig_idle_q <= 1'b0;
    else if (st_q == ST_WAIT && reading_new && !cont_q)
      trig_idle_q <= 1'b1;
  end

  // RQ18 latest reading is held until a newer one arrives
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reading_q <= '0;
    else if (reading_new)
      reading_q <= reading;
  end

  // Response shifter; the first character sits in the top byte.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tx_buf_q <= '0;
      tx_cnt_q <= 5'd0;
    end
    else
      unique case (ld)
        // RQ25 reading text
        LD_LAST, LD_NEW:
        begin
          tx_buf_q <= fmt_reading(ld == LD_NEW ? reading : reading_q);
          tx_cnt_q <= (ld == LD_NEW ? reading.exp_neg : reading_q.exp_neg) ? 5'd15 : 5'd14;
        end
        LD_FN:
        begin
          tx_buf_q <= {64'h0, FN_NAME[func_q], CH_NL} << (8 * (5'd15 - FN_LEN[func_q]));
          tx_cnt_q <= FN_LEN[func_q] + 5'd1;
        end
        LD_IDN:
        begin
          tx_buf_q <= {IDN_TEXT, CH_NL, 56'h0};
          tx_cnt_q <= 5'd9;
        end
        LD_NONE:
          if (tx_valid && tx_ready)
          begin
            tx_buf_q <= {tx_buf_q[119:0], 8'h00};
            tx_cnt_q <= tx_cnt_q - 5'd1;
          end
      endcase
  end
  assign tx_valid = (st_q == ST_SEND) && (tx_cnt_q != 5'd0);
  assign tx_data = tx_buf_q[127:120];

  // A new error wins over a software clear in the same cycle.
  logic err_set;
  assign err_set = parse_err || ex_err;
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      err_flag_q <= 1'b0;
      err_code_q <= 16'h0000;
    end
    else if (err_set)
    begin
      err_flag_q <= 1'b1;
      err_code_q <= parse_err ? ERR_UNDEF : ex_code;
    end
    else if (wr_ok && wb_req.adr == REG_ERR && wb_req.sel[2])
      err_flag_q <= 1'b0;
  end

  // Wishbone slave: one wait state, unmapped reads return zero.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
      if (wb_req.cyc && wb_req.stb && !ack_q)
        unique case (wb_req.adr)
          REG_CTRL: dat_q <= {27'h0, az_q, timm_q, buf_q, math_q, cont_q};
          REG_STAT: dat_q <= {6'h0, buf_count, 7'h0, tx_valid, func_q, trig_idle_q, st_q};
          REG_ERR: dat_q <= {15'h0, err_flag_q, err_code_q};
          REG_DELAY: dat_q <= {16'h0, delay_q};
          default: dat_q <= 32'h0000_0000;
        endcase
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  assign meas_ctl.abort = (st_q == ST_ABORT);
  assign meas_ctl.restart = (st_q == ST_ABORT) && cont_q;
  assign meas_ctl.init = (st_q == ST_INIT) && !cont_q;
  assign meas_ctl.configure = (st_q == ST_CONF);
  assign meas_ctl.store_abort = (st_q == ST_CONF);
  assign meas_ctl.rst = (st_q == ST_EXEC) && !bad_q && cmd_q && common_q && common_tok_q == TK_RST;
  assign meas_ctl.trg = (st_q == ST_EXEC) && !bad_q && cmd_q && common_q && common_tok_q == TK_TRG;
  assign func = func_q;
  assign trig_idle = trig_idle_q;

  conf_cont_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ14
    st_q == ST_CONF |=> !cont_q && func_q == $past(pend_fn_q)) else $error("continuous kept");
  conf_trig_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ15
    st_q == ST_CONF |=> timm_q && delay_q == 16'h0000) else $error("trigger not reset");
  conf_math_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ16
    st_q == ST_CONF |-> meas_ctl.store_abort ##1 !math_q && !buf_q && az_q == AZ_RST)
    else $error("math or buffer left on");
  meas_order_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ11
    st_q == ST_ABORT && do_conf_q && do_read_q |=> st_q == ST_CONF ##1 st_q == ST_ABORT
    ##1 st_q == ST_INIT) else $error("measure order wrong");
  read_mem_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ22
    st_q == ST_EXEC && !bad_q && cmd_q && !common_q && path_q[0] == TK_READ && query_q &&
    buf_count != 10'h000 |=> st_q == ST_RX && err_flag_q && err_code_q == ERR_OOM)
    else $error("read not refused");
  fetch_err_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ19
    st_q == ST_EXEC && !bad_q && cmd_q && !common_q && path_q[0] == TK_FETC && query_q && !cont_q
    |=> err_code_q == ERR_FETCH && st_q == ST_RX) else $error("fetch error missing");
  init_ign_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ21
    st_q == ST_INIT && cont_q |=> st_q == ST_SEND && err_code_q == ERR_INIT)
    else $error("init ignored wrong");
  abort_idle_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ13
    st_q == ST_ABORT && !cont_q |=> trig_idle_q) else $error("abort did not idle");
  semi_root_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ8
    take && ch == CH_COLON && wlen_q == 4'h0 && after_semi_q && !skip_q |=> lvl_q == 2'd0)
    else $error("path not reset");
  star_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ4
    take && ch == CH_STAR && !at_start_q && !skip_q |=> skip_q && bad_q)
    else $error("star accepted mid command");
  reading_fmt_a: assert property (@(posedge clk) disable iff (!reset_n) // RQ25
    ld == LD_LAST |=> tx_buf_q[111:104] == CH_DOT && tx_buf_q[127:120] ==
    ($past(reading_q.neg) ? CH_MINUS : CH_PLUS)) else $error("reading text wrong");

endmodule : scp_parser

// ---- scp_host_model.sv ----
// Purpose: Remote controller model that feeds command bytes and collects replies.
// Assumes: One byte moves per handshake on each stream.
// Notes: Replies are taken only every other cycle, so the sender sees stalls.
`timescale 1ns/1ps
module scp_host_model
(
  input wire logic clk,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] q[$];
  logic [255:0] got;
  initial {rx_valid, rx_data, tx_ready, got} = '0;
  task automatic send(input string s);
    foreach (s[i]) q.push_back(s[i]);
  endtask : send
  always @(posedge clk)
  begin
    tx_ready <= ~tx_ready;
    if (tx_valid && tx_ready) got <= {got[247:0], tx_data};
    if (!rx_valid || rx_ready)
    begin
      rx_valid <= q.size() != 0;
      // An idle data line toggles, so a stale byte can never look valid.
      rx_data <= (q.size() != 0) ? q.pop_front() : ~rx_data;
    end
  end
endmodule : scp_host_model

// ---- test_scp_parser.sv ----
// Purpose: Self-checking bench for the command interpreter.
// Assumes: A new reading arrives every 32 cycles.
// Notes: Replies are compared as right aligned text.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_scp_parser import scp_pkg::*;;
  typedef struct {logic [7:0] ctrl; logic [9:0] nb; string cmd; logic [255:0] rsp;
    logic [16:0] err;} scp_tb_row_t;
  localparam logic [255:0] RD = "+1.234567E-003\n";
  logic clk = 0, reset_n = 0, reading_new = 0, rx_valid, tx_valid, tx_ready, rx_ready;
  logic wb_ack_o, trig_idle;
  logic [7:0] rx_data, tx_data;
  logic [31:0] wb_dat_o, rd;
  logic [9:0] buf_count = '0;
  logic [4:0] tick = '0;
  scp_wb_req_t wb_req = '0;
  scp_meas_ctl_t meas_ctl;
  scp_func_t func;
  scp_reading_t reading = '{1'b0, 28'h123_4567, 1'b1, 12'h003};
  int checked = 0, n_mismatch = 0;
  string fw[10] = '{"VOLT:DC", "VOLT:AC", "CURR:DC", "CURR:AC", "RES", "FRES", "FREQ",
    "PER", "DIOD", "CONT"};
  scp_tb_row_t rows[9] = '{
    '{8'h18, 10'h000, "CONF:FREQ;:conf?\n", "freq\n", '0},
    '{8'h18, 10'h000, ":CONFIGURE:FRESISTANCE\nCONF?\n", "fres\n", '0},
    '{8'h18, 10'h000, "MEAS:VOLT:AC?\n", RD, '0},
    '{8'h18, 10'h000, "CONF?;*IDN?\n", "volt:ac\nXDMM,000\n", '0},
    '{8'h19, 10'h000, "FETC?\n", RD, '0},
    '{8'h18, 10'h000, "FETC?\n", '0, 17'h1_ff1a},
    '{8'h18, 10'h001, "READ?\n", '0, 17'h1_ff1f},
    '{8'h19, 10'h000, "READ?\n", RD, 17'h1_ff2b},
    '{8'h18, 10'h000, "BOGUS;CONF?\n", "volt:ac\n", 17'h1_ff8f}};
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    tick <= tick + 5'h01;
    reading_new <= tick == 5'h00;
  end
  scp_parser i_dut (.clk(clk), .reset_n(reset_n), .wb_req(wb_req), .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .reading(reading),
    .reading_new(reading_new), .buf_count(buf_count), .meas_ctl(meas_ctl), .func(func),
    .trig_idle(trig_idle));
  scp_host_model i_host (.clk(clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    for (k = 0; k < 20 && !wb_ack_o; k++) @(posedge clk);
    rd = wb_dat_o;
    wb_req <= '0;
    if (k == 20) begin n_mismatch++; end_sim(); end
  endtask : wb
  // Done once the line is drained and both streams stay quiet for three cycles.
  task automatic run(input string s);
    int k, idle;
    i_host.got = '0;
    i_host.send(s);
    idle = 0;
    for (k = 0; k < 3000 && idle < 3; k++)
    begin
      @(posedge clk);
      idle = (rx_ready && !rx_valid && !tx_valid && i_host.q.size() == 0) ? idle + 1 : 0;
    end
    if (k == 3000) begin n_mismatch++; end_sim(); end
  endtask : run
  initial
  begin
    int i;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    wb(1'b0, REG_CTRL, '0);
    `CHK(rd, 32'h0000_0018)
    wb(1'b0, 8'hf0, '0);
    `CHK(rd, 32'h0000_0000)
    foreach (rows[j])
    begin
      wb(1'b1, REG_CTRL, {24'h00_0000, rows[j].ctrl});
      buf_count <= rows[j].nb;
      run(rows[j].cmd);
      `CHK(i_host.got, rows[j].rsp)
      if (rows[j].err != '0)
      begin
        wb(1'b0, REG_ERR, '0);
        `CHK(rd[16:0], rows[j].err)
      end
    end
    for (i = 0; i < 10; i++)
    begin
      run({"CONF:", fw[i], "\n"});
      `CHK(func, scp_func_t'(i))
    end
    run("CONF:FREQ;PER\n");
    `CHK(func, FN_PER)
    reading <= '{1'b1, 28'h765_4321, 1'b0, 12'h012};
    run("MEAS:CONT?\n");
    `CHK(i_host.got, 256'("-7.654321E012\n"))
    wb(1'b1, REG_ERR, '0);
    wb(1'b0, REG_ERR, '0);
    `CHK(rd[16], 1'b0)
    run("CONF*IDN?\n");
    wb(1'b0, REG_ERR, '0);
    `CHK(rd[16:0], 17'h1_ff8f)
    wb(1'b1, REG_CTRL, 32'h0000_001f);
    wb(1'b1, REG_DELAY, 32'h0000_0055);
    run("conf:diode\n");
    `CHK(func, FN_DIODE)
    wb(1'b0, REG_CTRL, '0);
    `CHK(rd[4:0], 5'h18)
    wb(1'b0, REG_DELAY, '0);
    `CHK(rd[15:0], 16'h0000)
    `CHK(trig_idle, 1'b1)
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    run(";\n");
    wb(1'b0, REG_CTRL, '0);
    `CHK(rd[4:0], 5'h01)
    end_sim();
  end
endmodule : test_scp_parser
